// ===== hppc_config.sv
// Hub port power configuration bytes and their application
// What this block does
// - Bits four to one disable ports four..one
// - Offset 9 mask applies when self-powered
// - Offset A mask applies when bus-powered
// - Bits 7..5 reserved, bit 0 reads zero
// - Self-powered draw is offset B times 2mA
// - Bus-powered draw is offset C times 2mA
// - Controller self current offset D times 2mA
// - Controller self current defaults to fifty
// - Mode from select bit, or sense pin
// - Compound flag from the compound_device input
`timescale 1ns/1ps
`default_nettype none
`include "hppc_map.svh"
module hppc_config
  import hppc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration load port
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Power mode controls
  input wire logic power_source_select,
  input wire logic dynamic_power_enable,
  input wire logic local_power_sense_pin,
  input wire logic compound_device,
  // Hub core port requests
  input wire logic [3:0] port_req,
  // Applied results
  output logic self_powered,
  output logic [3:0] port_enabled,
  output logic [3:0] port_granted,
  output logic [7:0] active_draw,
  output logic [9:0] active_draw_ma,
  output logic [9:0] controller_current_ma,
  output logic embedded_included
);
  hppc_byte_t sp_off_r, sp_off_nxt;
  hppc_byte_t bp_off_r, bp_off_nxt;
  hppc_byte_t sp_draw_r, sp_draw_nxt;
  hppc_byte_t bp_draw_r, bp_draw_nxt;
  hppc_byte_t ctl_cur_r, ctl_cur_nxt;
  hppc_mode_t mode_r, mode_nxt;
  logic [7:0] act_mask;
  logic [7:0] draw_r, draw_nxt;

  // Load port: one byte per strobe, reserved mask bits dropped
  always_comb begin
    sp_off_nxt = sp_off_r;
    bp_off_nxt = bp_off_r;
    sp_draw_nxt = sp_draw_r;
    bp_draw_nxt = bp_draw_r;
    ctl_cur_nxt = ctl_cur_r;
    if (cfg_wr) begin
      unique case (cfg_addr)
        `HPPC_OFS_SP_PORT_OFF: sp_off_nxt = cfg_wdata & `HPPC_PORT_FIELD;
        `HPPC_OFS_BP_PORT_OFF: bp_off_nxt = cfg_wdata & `HPPC_PORT_FIELD;
        `HPPC_OFS_SP_DRAW: sp_draw_nxt = cfg_wdata;
        `HPPC_OFS_BP_DRAW: bp_draw_nxt = cfg_wdata;
        `HPPC_OFS_CTRL_SP_CUR: ctl_cur_nxt = cfg_wdata;
        default: ;
      endcase
    end
  end

  // Mode choice: sense pin overrides the select bit under dynamic switching
  always_comb begin
    if (dynamic_power_enable) begin
      mode_nxt = local_power_sense_pin ? HPPC_MODE_SELF : HPPC_MODE_BUS;
    end else begin
      mode_nxt = power_source_select ? HPPC_MODE_SELF : HPPC_MODE_BUS;
    end
  end

  // Draw follows the next mode so it swaps on the same edge as self_powered
  always_comb begin
    draw_nxt = (mode_nxt == HPPC_MODE_SELF) ? sp_draw_nxt : bp_draw_nxt;
  end

  // Configuration bytes and applied mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_off_r <= `HPPC_RST_PORT_OFF;
      bp_off_r <= `HPPC_RST_PORT_OFF;
      sp_draw_r <= `HPPC_RST_DRAW;
      bp_draw_r <= `HPPC_RST_DRAW;
      ctl_cur_r <= `HPPC_RST_CTRL_SP_CUR;
      mode_r <= HPPC_MODE_BUS;
      draw_r <= `HPPC_RST_DRAW;
    end else begin
      sp_off_r <= sp_off_nxt;
      bp_off_r <= bp_off_nxt;
      sp_draw_r <= sp_draw_nxt;
      bp_draw_r <= bp_draw_nxt;
      ctl_cur_r <= ctl_cur_nxt;
      mode_r <= mode_nxt;
      draw_r <= draw_nxt;
    end
  end

  // Read-back; offsets off the map read zero
  always_comb begin
    unique case (cfg_addr)
      `HPPC_OFS_SP_PORT_OFF: cfg_rdata = sp_off_r;
      `HPPC_OFS_BP_PORT_OFF: cfg_rdata = bp_off_r;
      `HPPC_OFS_SP_DRAW: cfg_rdata = sp_draw_r;
      `HPPC_OFS_BP_DRAW: cfg_rdata = bp_draw_r;
      `HPPC_OFS_CTRL_SP_CUR: cfg_rdata = ctl_cur_r;
      default: cfg_rdata = 8'h00;
    endcase
  end

  // Applied mode and figures, each byte step is 2 mA
  assign self_powered = (mode_r == HPPC_MODE_SELF);
  assign act_mask = self_powered ? sp_off_r : bp_off_r;
  assign active_draw = draw_r;
  assign active_draw_ma = {1'b0, draw_r, 1'b0};
  assign controller_current_ma = {1'b0, ctl_cur_r, 1'b0};
  assign embedded_included = compound_device;

  // Disabled ports are never offered downstream
  hppc_port_gate u_gate (
    .port_off_mask(act_mask),
    .port_req(port_req),
    .port_enabled(port_enabled),
    .port_granted(port_granted)
  );

  // Mask storage and read-back
  AST_BIT0_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    sp_off_r[0] == 1'b0 && bp_off_r[0] == 1'b0) else $error("reserved bit set");
  AST_RSV_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
    sp_off_r[7:5] == 3'h0 && bp_off_r[7:5] == 3'h0) else $error("reserved high bits set");
  AST_RD_BIT0: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_addr == `HPPC_OFS_SP_PORT_OFF || cfg_addr == `HPPC_OFS_BP_PORT_OFF) |-> cfg_rdata[0] == 1'b0)
    else $error("bit 0 read back set");

  // Read-back of each byte at its offset
  AST_RD_SP_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_addr == `HPPC_OFS_SP_PORT_OFF |-> cfg_rdata == sp_off_r) else $error("self mask read wrong");
  AST_RD_BP_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_addr == `HPPC_OFS_BP_PORT_OFF |-> cfg_rdata == bp_off_r) else $error("bus mask read wrong");
  AST_RD_SP_DRAW: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_addr == `HPPC_OFS_SP_DRAW |-> cfg_rdata == sp_draw_r) else $error("self draw read wrong");
  AST_RD_BP_DRAW: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_addr == `HPPC_OFS_BP_DRAW |-> cfg_rdata == bp_draw_r) else $error("bus draw read wrong");
  AST_RD_CUR: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_addr == `HPPC_OFS_CTRL_SP_CUR |-> cfg_rdata == ctl_cur_r) else $error("current read wrong");

  // Each strobe lands in its own byte, and nothing moves without one
  AST_SP_OFF_WR: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == `HPPC_OFS_SP_PORT_OFF |=> sp_off_r == ($past(cfg_wdata) & `HPPC_PORT_FIELD))
    else $error("self mask write lost");
  AST_BP_OFF_WR: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == `HPPC_OFS_BP_PORT_OFF |=> bp_off_r == ($past(cfg_wdata) & `HPPC_PORT_FIELD))
    else $error("bus mask write lost");
  AST_SP_DRAW_WR: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == `HPPC_OFS_SP_DRAW |=> sp_draw_r == $past(cfg_wdata))
    else $error("self draw write lost");
  AST_BP_DRAW_WR: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == `HPPC_OFS_BP_DRAW |=> bp_draw_r == $past(cfg_wdata))
    else $error("bus draw write lost");
  AST_CUR: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_wr && cfg_addr == `HPPC_OFS_CTRL_SP_CUR |=> controller_current_ma == {1'b0, $past(cfg_wdata), 1'b0})
    else $error("current wrong");
  AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !cfg_wr |=> $stable(sp_off_r) && $stable(bp_off_r) && $stable(sp_draw_r) && $stable(bp_draw_r)
      && $stable(ctl_cur_r)) else $error("byte changed without a write");

  // Figures reported in mA
  AST_DRAW: assert property (@(posedge clk) disable iff (!arst_n)
    active_draw_ma == 10'(active_draw) * 10'h002 && active_draw == (self_powered ? sp_draw_r : bp_draw_r))
    else $error("draw wrong");
  AST_CUR_MA: assert property (@(posedge clk) disable iff (!arst_n)
    controller_current_ma == 10'(ctl_cur_r) * 10'(`HPPC_UNIT_MA)) else $error("current scale wrong");

  // Mode choice, byte swap and port gating
  AST_MODE_CODE: assert property (@(posedge clk) disable iff (!arst_n)
    mode_r == HPPC_MODE_BUS || mode_r == HPPC_MODE_SELF) else $error("mode code illegal");
  AST_DYN: assert property (@(posedge clk) disable iff (!arst_n)
    dynamic_power_enable |=> self_powered == $past(local_power_sense_pin)) else $error("sense ignored");
  AST_DYN_OVER: assert property (@(posedge clk) disable iff (!arst_n)
    dynamic_power_enable && power_source_select != local_power_sense_pin
      |=> self_powered == $past(local_power_sense_pin)) else $error("select not overridden");
  AST_SEL: assert property (@(posedge clk) disable iff (!arst_n)
    !dynamic_power_enable |=> self_powered == $past(power_source_select)) else $error("select ignored");
  AST_SWAP: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(self_powered) |-> active_draw == (self_powered ? sp_draw_r : bp_draw_r)
      && port_enabled == ~act_mask[`HPPC_PORT_MSB:`HPPC_PORT_LSB]) else $error("bytes not swapped with mode");
  AST_SP_MASK: assert property (@(posedge clk) disable iff (!arst_n)
    self_powered |-> port_enabled == ~sp_off_r[4:1]) else $error("self mask wrong");
  AST_BP_MASK: assert property (@(posedge clk) disable iff (!arst_n)
    !self_powered |-> port_enabled == ~bp_off_r[4:1]) else $error("bus mask wrong");
  AST_PORT_BITS: assert property (@(posedge clk) disable iff (!arst_n)
    port_enabled == ~act_mask[`HPPC_PORT_MSB:`HPPC_PORT_LSB]) else $error("port bit order wrong");
  AST_GRANT: assert property (@(posedge clk) disable iff (!arst_n)
    (port_granted & ~port_enabled) == 4'h0) else $error("disabled port granted");
  AST_GRANT_AND: assert property (@(posedge clk) disable iff (!arst_n)
    port_granted == (port_req & port_enabled)) else $error("available port refused");
  AST_CMP: assert property (@(posedge clk) disable iff (!arst_n)
    embedded_included == compound_device) else $error("compound wrong");

  // Defaults while reset is held
  AST_RST_VAL: assert property (@(posedge clk)
    !arst_n |-> ctl_cur_r == `HPPC_RST_CTRL_SP_CUR && sp_off_r == `HPPC_RST_PORT_OFF
      && bp_off_r == `HPPC_RST_PORT_OFF && sp_draw_r == `HPPC_RST_DRAW && bp_draw_r == `HPPC_RST_DRAW)
    else $error("defaults not held in reset");
  AST_RST_PORTS: assert property (@(posedge clk)
    !arst_n |-> !self_powered && port_enabled == 4'hF) else $error("ports not free in reset");

  // Main scenarios
  COV_SWITCH: cover property (@(posedge clk) disable iff (!arst_n) $rose(self_powered));
  COV_DROP: cover property (@(posedge clk) disable iff (!arst_n) $fell(self_powered));
  COV_DIS: cover property (@(posedge clk) disable iff (!arst_n) port_req != 4'h0 && port_granted == 4'h0);
  COV_SENSE: cover property (@(posedge clk) disable iff (!arst_n)
    dynamic_power_enable && $changed(local_power_sense_pin));
  COV_CUR_WR: cover property (@(posedge clk) disable iff (!arst_n) cfg_wr && cfg_addr == `HPPC_OFS_CTRL_SP_CUR);
endmodule : hppc_config
`default_nettype wire

// ===== hppc_map.svh
// Register offsets, field positions and reset values of the hub port power configuration
`ifndef HPPC_MAP_SVH
`define HPPC_MAP_SVH
`define HPPC_OFS_SP_PORT_OFF 8'h09
`define HPPC_OFS_BP_PORT_OFF 8'h0A
`define HPPC_OFS_SP_DRAW 8'h0B
`define HPPC_OFS_BP_DRAW 8'h0C
`define HPPC_OFS_CTRL_SP_CUR 8'h0D
`define HPPC_PORT_LSB 1
`define HPPC_PORT_MSB 4
`define HPPC_PORT_FIELD 8'h1E
`define HPPC_RST_PORT_OFF 8'h00
`define HPPC_RST_DRAW 8'h00
`define HPPC_RST_CTRL_SP_CUR 8'h32
`define HPPC_UNIT_MA 2
`endif

// ===== hppc_pkg.sv
// Types shared by the hub port power configuration block
`default_nettype none
package hppc_pkg;
  typedef enum logic [1:0] {
    HPPC_MODE_BUS = 2'b01,
    HPPC_MODE_SELF = 2'b10
  } hppc_mode_t;
  typedef logic [7:0] hppc_byte_t;
  typedef logic [3:0] hppc_ports_t;
endpackage : hppc_pkg
`default_nettype wire

// ===== hppc_port_gate.sv
// Per-port availability from the active disable mask
`timescale 1ns/1ps
`default_nettype none
`include "hppc_map.svh"
module hppc_port_gate
  import hppc_pkg::*;
(
  // Active disable byte
  input wire logic [7:0] port_off_mask,
  // Per-port request from the hub core
  input wire logic [3:0] port_req,
  // Results
  output logic [3:0] port_enabled,
  output logic [3:0] port_granted
);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_port
      assign port_enabled[gi] = ~port_off_mask[gi + `HPPC_PORT_LSB];
      assign port_granted[gi] = port_req[gi] & port_enabled[gi];
    end
  endgenerate
endmodule : hppc_port_gate
`default_nettype wire

// ===== hppc_loader.sv
// Model of the configuring memory that loads the bytes
`timescale 1ns/1ps
`default_nettype none
module hppc_loader (
  // Clock
  input wire logic clk,
  // Load port
  output var logic cfg_wr,
  output var logic [7:0] cfg_addr,
  output var logic [7:0] cfg_wdata
);
  initial begin
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end
  // Contiguous run of ports, bits 7..5 and 0 clear
  function automatic logic [7:0] run_mask(input int unsigned r1, input int unsigned r2);
    int unsigned lo = r1 % 4;
    int unsigned n = 1 + r2 % (4 - lo);
    return 8'(((1 << n) - 1) << (lo + 1));
  endfunction : run_mask
  task automatic load(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #2;
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask : load
endmodule : hppc_loader
`default_nettype wire

// ===== hub_port_power_config_tb.sv
// Self-checking bench for the hub port power configuration
`timescale 1ns/1ps
`default_nettype none
module hub_port_power_config_tb;
  import hppc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic pss = 1'b0, dpe = 1'b0, lps = 1'b0, cpd = 1'b0;
  logic [3:0] req = 4'h0;
  logic wr, sp, emb;
  logic [7:0] adr, wd, rd, ad;
  logic [3:0] pen, pgr;
  logic [9:0] adma, ccma;
  hppc_byte_t m [2];
  hppc_byte_t w [3];
  int n_mismatch = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  hppc_loader ld_u (.clk(clk), .cfg_wr(wr), .cfg_addr(adr), .cfg_wdata(wd));
  hppc_config dut_u (.clk(clk), .arst_n(arst_n), .cfg_wr(wr), .cfg_addr(adr), .cfg_wdata(wd),
    .cfg_rdata(rd), .power_source_select(pss), .dynamic_power_enable(dpe), .local_power_sense_pin(lps),
    .compound_device(cpd), .port_req(req), .self_powered(sp), .port_enabled(pen), .port_granted(pgr),
    .active_draw(ad), .active_draw_ma(adma), .controller_current_ma(ccma), .embedded_included(emb));
  task automatic cmp_v(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_v
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t read %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd
  function automatic logic exp_self();
    return dpe ? lps : pss;
  endfunction : exp_self
  task automatic check_all();
    logic s;
    hppc_byte_t mk;
    hppc_ports_t en;
    s = exp_self();
    mk = s ? m[0] : m[1];
    en = ~mk[4:1];
    cmp_v(sp, s);
    cmp_v(pen, en);
    cmp_v(pgr, req & en);
    cmp_v(ad, s ? w[0] : w[1]);
    cmp_v(adma, {1'b0, s ? w[0] : w[1], 1'b0});
    cmp_v(ccma, {1'b0, w[2], 1'b0});
    cmp_v(emb, cpd);
  endtask : check_all
  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin : main
    void'($urandom(87334));
    #2 arst_n = 1'b0;
    repeat (5) @(posedge clk);
    #2 arst_n = 1'b1;
    m = '{8'h00, 8'h00};
    w = '{8'h00, 8'h00, 8'h32};
    check_all();
    ld_u.load(8'h09, 8'hFF);
    m[0] = 8'h1E;
    cmp_rd(rd, 8'h1E);
    // Sense pin picks self power against the select bit: every port off
    {pss, dpe, lps, cpd} = 4'h6;
    req = 4'hF;
    repeat (2) @(posedge clk);
    #2 check_all();
    ld_u.load(8'h0E, 8'h5A);
    cmp_rd(rd, 8'h00);
    for (int i = 0; i < 40; i++) begin
      m[0] = ld_u.run_mask($urandom, $urandom);
      m[1] = ld_u.run_mask($urandom, $urandom);
      // Self-powered currents capped at 100 mA
      w[0] = 8'($urandom % 51);
      w[1] = 8'($urandom);
      w[2] = 8'($urandom % 51);
      for (int k = 0; k < 5; k++) begin
        ld_u.load(8'h09 + k[7:0], k < 2 ? m[k] : w[k - 2]);
        cmp_rd(rd, k < 2 ? m[k] : w[k - 2]);
      end
      {pss, dpe, lps, cpd} = 4'($urandom);
      req = 4'($urandom);
      repeat (2) @(posedge clk);
      #2 check_all();
    end
    // Reset in mid-run; the address still points at offset D
    {pss, dpe, lps, cpd} = 4'h0;
    @(posedge clk);
    #2 arst_n = 1'b0;
    m = '{8'h00, 8'h00};
    w = '{8'h00, 8'h00, 8'h32};
    @(posedge clk);
    #2 check_all();
    cmp_rd(rd, 8'h32);
    @(posedge clk);
    #2 arst_n = 1'b1;
    ld_u.load(8'h0A, 8'h06);
    m[1] = 8'h06;
    cmp_rd(rd, 8'h06);
    repeat (2) @(posedge clk);
    #2 check_all();
    end_of_test();
  end
  initial begin : watchdog
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule : hub_port_power_config_tb
`default_nettype wire
